//--- rtl/mras_pkg.sv
// Purpose: constants and types of the memory ras control block
// Assumes: classic 32-bit wishbone, four ranks, 250 MHz clock
// Notes: register offsets are byte addresses, one word each
// Functional notes
// R1: one rank of two-rank module spares
// R2: mirror keeps branch 0 and 1 identical
// R3: mirrored reads alternate between branches
// R4: mirrored writes go to both branches
// R5: firmware drops mirroring on unsuitable population
// R6: fatal or uncorrectable error raises halting nmi
// R7: recoverable error retried, success resumes normally
// R8: failed retry escalates to fatal error
// R9: firmware acts only on single-bit correctables
// R10: self-test each boot, failing ranks offline
// R11: southbound ten lanes, fail-over to nine
// R12: northbound fourteen lanes, fail-over to thirteen
// R13: lanes checked at init, failure sets fail-over
// R14: lanes checked at fast reset, runtime fail-over
// R15: firmware disables modules on failed link
// R16: no usable memory: firmware halts system
// R17: runtime link failure handled as fatal
// R18: correctable error increments its rank counter
// R19: counters decay at programmable rate
// R20: one counter per rank, threshold ten
// R21: spare fail-over only above threshold
// R22: firmware sets decay period by size
// R23: over threshold: copy to spare, retire rank
// R24: counter floors at zero, saturates at top
package mras_pkg;
  // geometry
  localparam int NRANK = 4;            // ranks under control
  localparam int CW    = 8;            // leaky counter width
  localparam int SBL   = 10;           // southbound lanes
  localparam int NBL   = 14;           // northbound lanes
  // register offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STAT   = 8'h04;
  localparam logic [7:0] OFS_DECAY  = 8'h08;
  localparam logic [7:0] OFS_THRESH = 8'h0c;
  localparam logic [7:0] OFS_CNT    = 8'h10;
  // control fields
  localparam int CTL_MIRROR = 0;       // mirroring on
  localparam int CTL_SPARE  = 1;       // sparing on
  localparam int CTL_SRANK  = 2;       // spare rank, 2 bits
  localparam int CTL_BOFF   = 4;       // branch disable, 2 bits
  // status fields
  localparam int ST_FATAL  = 0;        // fatal seen, write 1 clears
  localparam int ST_SPDONE = 1;        // spare fail-over, w1c
  localparam int ST_SBFO   = 2;        // southbound fail-over
  localparam int ST_NBFO   = 3;        // northbound fail-over
  localparam int ST_LINK   = 4;        // fatal link failure
  localparam int ST_STATE  = 5;        // sequencer state, 3 bits
  localparam int ST_ACT    = 8;        // active ranks, 4 bits
  localparam int ST_FAIL   = 12;       // self-test failed ranks
  // reset values
  localparam logic [CW-1:0] RST_THRESH = 8'h0a;
  // cycles to let lane synchronisers fill before first check
  localparam logic [1:0] SYNC_WAIT = 2'h2;

  // sequencer states
  typedef enum logic [2:0] {
    MS_INIT  = 3'b000,
    MS_BIST  = 3'b001,
    MS_RUN   = 3'b010,
    MS_FRST  = 3'b011,
    MS_RETRY = 3'b100,
    MS_COPY  = 3'b101
  } mras_state_t;

  // state of one leaky counter
  typedef struct packed {
    logic [CW-1:0] cnt;
  } mras_lbc_st_t;
endpackage : mras_pkg

//--- rtl/mras_lbc.sv
// Purpose: leaky bucket counter of one rank
// Assumes: inc and dec are single-cycle strobes on clk_i
// Notes: saturates at all ones, floors at zero
`timescale 1ns/1ps
module mras_lbc
  import mras_pkg::*;
(
  // clock, reset, enable
  input  logic          clk_i,
  input  logic          rst_i,
  input  logic          ce_i,
  // events
  input  logic          inc_i,
  input  logic          dec_i,
  input  logic          clr_i,
  // count
  output logic [CW-1:0] cnt_o
);
  mras_lbc_st_t s_q;   // registered state
  mras_lbc_st_t s_d;   // next state

  // next count; inc and dec together cancel out
  always_comb begin
    s_d = s_q;
    if (clr_i) begin
      s_d.cnt = '0;
    end else if (inc_i && !dec_i && s_q.cnt != '1) begin
      s_d.cnt = s_q.cnt + 1'b1; // R18
    end else if (dec_i && !inc_i && s_q.cnt != '0) begin
      s_d.cnt = s_q.cnt - 1'b1; // R19 R24
    end
  end

  // state register, frozen while ce_i is low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else if (ce_i) begin
      s_q <= s_d;
    end
  end

  assign cnt_o = s_q.cnt;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_lbc_inc_step: assert property ( // R18
    ce_i && inc_i && !dec_i && !clr_i && cnt_o != '1
    |=> cnt_o == $past(cnt_o) + 1'b1)
    else $error("counter did not step up");
  a_lbc_decay_step: assert property ( // R19
    ce_i && dec_i && !inc_i && !clr_i && cnt_o != '0
    |=> cnt_o == $past(cnt_o) - 1'b1)
    else $error("counter did not decay");
  a_lbc_floor_zero: assert property ( // R24
    cnt_o == '0 && !inc_i |=> cnt_o == '0)
    else $error("counter wrapped below zero");
  a_lbc_ceil_hold: assert property ( // R24
    cnt_o == '1 && !dec_i && !clr_i |=> cnt_o == '1)
    else $error("counter overflowed");
endmodule : mras_lbc

//--- rtl/mras_top.sv
// Purpose: mirroring, sparing, error escalation and lane fail-over
// Assumes: request and error inputs are on clk_i, lane status pins
//          are asynchronous
// Notes: registers on classic wishbone, ack one cycle after request
`timescale 1ns/1ps
module mras_top
  import mras_pkg::*;
(
  // clock, reset, enable
  input  logic             clk_i,
  input  logic             rst_i,
  input  logic             ce_i,
  // wishbone slave
  input  logic             wb_cyc_i,
  input  logic             wb_stb_i,
  input  logic             wb_we_i,
  input  logic [7:0]       wb_adr_i,
  input  logic [3:0]       wb_sel_i,
  input  logic [31:0]      wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // transaction steering
  input  logic             rd_req_i,
  input  logic             wr_req_i,
  input  logic             req_br_i,
  output logic [1:0]       rd_br_o,
  output logic [1:0]       wr_br_o,
  // error reports
  input  logic             fatal_err_i,
  input  logic             rec_err_i,
  input  logic             alert_i,
  input  logic             ce_err_i,
  input  logic [1:0]       ce_rank_i,
  output logic             nmi_o,
  // fast reset and retry handshakes
  output logic             frst_o,
  input  logic             frst_done_i,
  output logic             retry_o,
  input  logic             retry_done_i,
  input  logic             retry_ok_i,
  // self-test engine
  output logic             bist_run_o,
  input  logic             bist_done_i,
  input  logic [NRANK-1:0] bist_fail_i,
  // spare copy engine
  output logic             copy_o,
  output logic [1:0]       copy_src_o,
  output logic [1:0]       copy_dst_o,
  input  logic             copy_done_i,
  output logic [NRANK-1:0] act_rank_o,
  // lane pins and fail-over state
  input  logic [SBL-1:0]   sb_lane_ok_i,
  input  logic [NBL-1:0]   nb_lane_ok_i,
  output logic             sb_fo_o,
  output logic             nb_fo_o
);
  // whole state of the block
  typedef struct packed {
    mras_state_t      st;       // sequencer
    logic [1:0]       wcnt;     // init wait
    logic [SBL-1:0]   sb_s1;    // sync stage 1
    logic [SBL-1:0]   sb_s2;    // sync stage 2
    logic [NBL-1:0]   nb_s1;
    logic [NBL-1:0]   nb_s2;
    logic             mirror;   // control bits
    logic             spare_en;
    logic [1:0]       srank;
    logic [1:0]       boff;
    logic [31:0]      decay;    // decay tick interval
    logic [31:0]      pre;      // decay prescaler
    logic [CW-1:0]    thresh;   // sparing threshold
    logic             fatal;    // status bits
    logic             spdone;
    logic             sbfo;
    logic             nbfo;
    logic             link;
    logic [NRANK-1:0] act;      // active ranks
    logic [NRANK-1:0] fail;     // self-test failures
    logic [1:0]       src;      // rank being retired
    logic             rec_pend; // recoverable error waiting
    logic             al_pend;  // alert waiting
    logic             need_rt;  // retry after fast reset
    logic             alt;      // mirrored read toggle
    logic             ack;      // bus answer
    logic [31:0]      dat;      // bus read data
  } mras_top_st_t;

  mras_top_st_t     st_q;             // registered state
  mras_top_st_t     st_d;             // next state
  logic [CW-1:0]    cnt_w [NRANK];    // counter values
  logic [NRANK-1:0] over;             // rank above threshold
  logic [NRANK-1:0] spare_mask;       // spare rank one-hot
  logic             tick;             // decay strobe
  logic             hit;              // some rank needs sparing
  logic [1:0]       hit_rank;         // lowest such rank
  logic             sb_one, sb_many;  // failed lane counts
  logic             nb_one, nb_many;
  logic             req;              // bus cycle present
  logic             rd_alt;           // mirrored read, alternating branch
  logic [31:0]      rdata;            // read mux
  logic [31:0]      mrg;              // byte-merged write

  // byte-lane merge of a write
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) r[b*8 +: 8] = nw[b*8 +: 8];
    end
    return r;
  endfunction : merge

  // one leaky counter per rank
  for (genvar g = 0; g < NRANK; g++) begin : g_lbc
    mras_lbc u_lbc (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .ce_i  (ce_i),
      .inc_i (ce_err_i && ce_rank_i == 2'(g)),     // R18 R20
      .dec_i (tick),                                // R19
      .clr_i (copy_done_i && st_q.st == MS_COPY &&
              st_q.src == 2'(g)),
      .cnt_o (cnt_w[g])
    );
  end

  // lane health after the synchroniser; one bad lane is survivable
  assign sb_one  = $countones(~st_q.sb_s2) == 1;   // R11
  assign sb_many = $countones(~st_q.sb_s2) > 1;
  assign nb_one  = $countones(~st_q.nb_s2) == 1;   // R12
  assign nb_many = $countones(~st_q.nb_s2) > 1;

  // decay strobe; interval zero switches decay off
  assign tick = st_q.decay != '0 && st_q.pre == st_q.decay - 1'b1;

  assign spare_mask = st_q.spare_en ? NRANK'(1) << st_q.srank : '0;

  // lowest active, non-spare rank whose count exceeds the threshold
  always_comb begin
    hit      = 1'b0;
    hit_rank = '0;
    for (int i = 0; i < NRANK; i++) begin
      over[i] = cnt_w[i] > st_q.thresh && st_q.act[i] &&
                !spare_mask[i];                     // R21
    end
    for (int i = NRANK - 1; i >= 0; i--) begin
      if (over[i]) begin
        hit      = 1'b1;
        hit_rank = 2'(i);
      end
    end
  end

  // register read mux; unmapped words read zero
  always_comb begin
    rdata = '0;
    unique case (wb_adr_i)
      OFS_CTRL: begin
        rdata[CTL_MIRROR]       = st_q.mirror;
        rdata[CTL_SPARE]        = st_q.spare_en;
        rdata[CTL_SRANK +: 2]   = st_q.srank;
        rdata[CTL_BOFF +: 2]    = st_q.boff;
      end
      OFS_STAT: begin
        rdata[ST_FATAL]         = st_q.fatal;
        rdata[ST_SPDONE]        = st_q.spdone;
        rdata[ST_SBFO]          = st_q.sbfo;
        rdata[ST_NBFO]          = st_q.nbfo;
        rdata[ST_LINK]          = st_q.link;
        rdata[ST_STATE +: 3]    = st_q.st;
        rdata[ST_ACT +: NRANK]  = st_q.act;
        rdata[ST_FAIL +: NRANK] = st_q.fail;
      end
      OFS_DECAY:  rdata = st_q.decay;
      OFS_THRESH: rdata[CW-1:0] = st_q.thresh;
      OFS_CNT: begin
        for (int i = 0; i < NRANK; i++) rdata[i*CW +: CW] = cnt_w[i];
      end
      default: rdata = '0;
    endcase
  end

  assign req = wb_cyc_i && wb_stb_i;
  assign mrg = merge(rdata, wb_dat_i, wb_sel_i);

  // next-state logic: bus first so hardware sets win over clears
  always_comb begin
    st_d       = st_q;
    // synchronisers: stage 1 feeds stage 2 only
    st_d.sb_s1 = sb_lane_ok_i;
    st_d.sb_s2 = st_q.sb_s1;
    st_d.nb_s1 = nb_lane_ok_i;
    st_d.nb_s2 = st_q.nb_s1;
    // decay prescaler
    st_d.pre   = tick || st_q.decay == '0 ? '0 : st_q.pre + 1'b1;
    // bus: ack and data one cycle after the request appears
    st_d.ack   = req && !st_q.ack;
    if (req && !st_q.ack) st_d.dat = rdata;
    // writes land at the edge where the master sees ack
    if (req && st_q.ack && wb_we_i) begin
      unique case (wb_adr_i)
        OFS_CTRL: begin
          st_d.mirror   = mrg[CTL_MIRROR];
          st_d.spare_en = mrg[CTL_SPARE];
          st_d.srank    = mrg[CTL_SRANK +: 2];
          st_d.boff     = mrg[CTL_BOFF +: 2];
        end
        OFS_STAT: begin
          if (wb_sel_i[0] && wb_dat_i[ST_FATAL])  st_d.fatal  = 1'b0;
          if (wb_sel_i[0] && wb_dat_i[ST_SPDONE]) st_d.spdone = 1'b0;
        end
        OFS_DECAY:  st_d.decay  = mrg;
        OFS_THRESH: st_d.thresh = mrg[CW-1:0];
        default: ;  // read-only or unmapped: ignored
      endcase
    end
    // mirrored reads flip branch on each request
    if (rd_alt) st_d.alt = !st_q.alt;                // R3
    // sequencer
    unique case (st_q.st)
      MS_INIT: begin
        // wait for synchronised lane status, then check lanes
        st_d.wcnt = st_q.wcnt + 1'b1;
        if (st_q.wcnt == SYNC_WAIT) begin
          st_d.sbfo = sb_one;                        // R13 R11
          st_d.nbfo = nb_one;                        // R13 R12
          st_d.link = sb_many || nb_many;            // R15
          st_d.st   = MS_BIST;
        end
      end
      MS_BIST: begin
        // self-test engine isolates failing ranks
        if (bist_done_i) begin
          st_d.fail = bist_fail_i;                   // R10
          st_d.act  = ~bist_fail_i & ~spare_mask;    // R10 R1
          st_d.st   = MS_RUN;
        end
      end
      MS_RUN: begin
        if (st_q.rec_pend || st_q.al_pend) begin
          st_d.need_rt  = st_q.rec_pend;             // R7
          st_d.rec_pend = 1'b0;
          st_d.al_pend  = 1'b0;
          st_d.st       = MS_FRST;                   // R14
        end else if (hit && st_q.spare_en && !st_q.spdone) begin
          st_d.src = hit_rank;                       // R23
          st_d.st  = MS_COPY;
        end
      end
      MS_FRST: begin
        // lanes are re-checked while the modules reset
        if (frst_done_i) begin
          if (sb_one) st_d.sbfo = 1'b1;              // R14 R11
          if (nb_one) st_d.nbfo = 1'b1;              // R14 R12
          if (sb_many || nb_many) begin
            st_d.link  = 1'b1;
            st_d.fatal = 1'b1;                       // R17
          end
          st_d.st = st_q.need_rt ? MS_RETRY : MS_RUN;
        end
      end
      MS_RETRY: begin
        if (retry_done_i) begin
          if (!retry_ok_i) st_d.fatal = 1'b1;        // R8
          st_d.st = MS_RUN;                          // R7
        end
      end
      MS_COPY: begin
        // spare takes over, failing rank leaves the active set
        if (copy_done_i) begin
          st_d.act[st_q.src]   = 1'b0;               // R23
          st_d.act[st_q.srank] = 1'b1;
          st_d.spdone          = 1'b1;               // R21
          st_d.st              = MS_RUN;
        end
      end
      default: st_d.st = MS_INIT;  // two codes are unused
    endcase
    // events are latched last so they beat any clear
    if (rec_err_i) st_d.rec_pend = 1'b1;
    if (alert_i) st_d.al_pend = 1'b1;
    if (fatal_err_i) st_d.fatal = 1'b1;              // R6
  end

  // state register; reset gives threshold ten, all else zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q        <= '0;
      st_q.thresh <= RST_THRESH;                     // R20
    end else if (ce_i) begin
      st_q <= st_d;
    end
  end

  // steering: mirrored writes to both images unless one is off
  assign rd_alt = rd_req_i && st_q.mirror && st_q.boff == 2'b00;
  always_comb begin
    rd_br_o = '0;
    wr_br_o = '0;
    if (rd_req_i) begin
      if (rd_alt) rd_br_o = st_q.alt ? 2'b10 : 2'b01;  // R2 R3
      else if (st_q.mirror) rd_br_o = ~st_q.boff;
      else rd_br_o = req_br_i ? 2'b10 : 2'b01;
    end
    if (wr_req_i) begin
      if (st_q.mirror) wr_br_o = ~st_q.boff;          // R2 R4
      else wr_br_o = req_br_i ? 2'b10 : 2'b01;
    end
  end

  // outputs decoded from registers
  assign wb_ack_o   = st_q.ack;
  assign wb_dat_o   = st_q.dat;
  assign nmi_o      = st_q.fatal;                     // R6
  assign frst_o     = st_q.st == MS_FRST;
  assign retry_o    = st_q.st == MS_RETRY;
  assign bist_run_o = st_q.st == MS_BIST;
  assign copy_o     = st_q.st == MS_COPY;
  assign copy_src_o = st_q.src;
  assign copy_dst_o = st_q.srank;
  assign act_rank_o = st_q.act;
  assign sb_fo_o    = st_q.sbfo;
  assign nb_fo_o    = st_q.nbfo;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_wr_both_br: assert property ( // R4
    wr_req_i && st_q.mirror && st_q.boff == 2'b00
    |-> wr_br_o == 2'b11)
    else $error("mirrored write missed a branch");
  a_rd_alternate: assert property ( // R3
    rd_alt && ce_i ##1 rd_alt |-> rd_br_o != $past(rd_br_o))
    else $error("mirrored reads did not alternate");
  a_rd_one_br: assert property ( // R2
    rd_alt |-> $onehot(rd_br_o))
    else $error("mirrored read not to one branch");
  a_fatal_nmi: assert property ( // R6
    fatal_err_i && ce_i |=> nmi_o)
    else $error("fatal error gave no nmi");
  a_retry_ok_run: assert property ( // R7
    ce_i && retry_o && retry_done_i && retry_ok_i && !nmi_o
    && !fatal_err_i |=> !retry_o && !nmi_o)
    else $error("good retry did not resume");
  a_retry_bad_fatal: assert property ( // R8
    ce_i && retry_o && retry_done_i && !retry_ok_i
    |=> nmi_o && !retry_o)
    else $error("failed retry not escalated");
  a_bist_offline: assert property ( // R10
    ce_i && bist_run_o && bist_done_i
    |=> (act_rank_o & $past(bist_fail_i)) == '0 && !bist_run_o)
    else $error("failed rank left active");
  a_init_lane_fo: assert property ( // R13
    ce_i && st_q.st == MS_INIT && st_q.wcnt == SYNC_WAIT
    |=> sb_fo_o == $past(sb_one) && nb_fo_o == $past(nb_one))
    else $error("init lane check wrong");
  a_frst_sb_fo: assert property ( // R11
    ce_i && frst_o && frst_done_i && sb_one |=> sb_fo_o)
    else $error("southbound fail-over not set");
  a_frst_nb_fo: assert property ( // R12
    ce_i && frst_o && frst_done_i && nb_one |=> nb_fo_o)
    else $error("northbound fail-over not set");
  a_rec_frst: assert property ( // R14
    ce_i && st_q.st == MS_RUN && st_q.rec_pend |=> frst_o)
    else $error("recoverable error skipped fast reset");
  a_spare_cause: assert property ( // R21
    st_q.st == MS_RUN && st_d.st == MS_COPY |-> over[st_d.src])
    else $error("spare copy without threshold hit");
  a_copy_retire: assert property ( // R23
    ce_i && copy_o && copy_done_i
    |=> !act_rank_o[$past(copy_src_o)] && act_rank_o[copy_dst_o])
    else $error("failing rank not retired");
  a_spare_held: assert property ( // R1
    ce_i && bist_run_o && bist_done_i && st_q.spare_en
    |=> !act_rank_o[st_q.srank])
    else $error("spare rank left active");
  a_thresh_reset: assert property ( // R20
    $fell(rst_i) |-> st_q.thresh == RST_THRESH)
    else $error("threshold not ten after reset");
endmodule : mras_top

//--- tb/mras_dimm_model.sv
// Purpose: behavioural memory modules behind the ras block
// Assumes: the controller raises one request level at a time
// Notes: every request gets a done pulse DLY cycles later
`timescale 1ns/1ps
module mras_dimm_model #(
  parameter int DLY = 8                 // answer delay in cycles
) (
  // clock and reset
  input  logic       clk_i,
  input  logic       rst_i,
  // requests from the controller
  input  logic       frst_i,
  input  logic       retry_i,
  input  logic       bist_i,
  input  logic       copy_i,
  // scenario settings from the bench
  input  logic       ok_i,
  input  logic [3:0] fail_i,
  // answers
  output logic       frst_done_o,
  output logic       retry_done_o,
  output logic       retry_ok_o,
  output logic       bist_done_o,
  output logic [3:0] bist_fail_o,
  output logic       copy_done_o
);
  logic [7:0] cnt_q;                    // cycles since request seen
  logic       any;                      // some request pending
  logic       hit;                      // answer due now
  assign any = frst_i | retry_i | bist_i | copy_i;
  assign hit = any && (cnt_q == 8'(DLY));
  // one shared timer: requests never overlap
  always @(posedge clk_i) begin
    cnt_q        <= (rst_i || hit || !any) ? 8'h00 : cnt_q + 8'h01;
    frst_done_o  <= hit & frst_i;
    retry_done_o <= hit & retry_i;
    // result lines show junk outside the done cycle
    retry_ok_o   <= hit ? ok_i : ~ok_i;
    bist_done_o  <= hit & bist_i;
    bist_fail_o  <= hit ? fail_i : ~fail_i;
    copy_done_o  <= hit & copy_i;
  end
endmodule : mras_dimm_model

//--- tb/testbench.sv
// Purpose: self-checking bench of the memory ras control block
// Assumes: ce_i tied high, model answers after eight cycles
// Notes: all checks sample at rising edges
`timescale 1ns/1ps
module testbench import mras_pkg::*;;
  // bench driven inputs
  logic clk_i = 0, rst_i = 1, ce_i = 1;
  logic wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [7:0] wb_adr_i = 0;
  logic [3:0] wb_sel_i = 0;
  logic [31:0] wb_dat_i = 0;
  logic rd_req_i = 0, wr_req_i = 0, req_br_i = 0;
  logic fatal_err_i = 0, rec_err_i = 0, alert_i = 0, ce_err_i = 0;
  logic [1:0] ce_rank_i = 0;
  logic [SBL-1:0] sb_lane_ok_i = 10'h3ff;
  logic [NBL-1:0] nb_lane_ok_i = 14'h3ffe;   // one bad north lane
  logic ok_set = 1;
  logic [3:0] fail_set = 4'h2;                // rank 1 fails self-test
  // design outputs and model answers
  logic [31:0] wb_dat_o, rd;
  logic wb_ack_o, nmi_o, frst_o, frst_done_i, retry_o, retry_done_i;
  logic retry_ok_i, bist_run_o, bist_done_i, copy_o, copy_done_i;
  logic sb_fo_o, nb_fo_o;
  logic [1:0] rd_br_o, wr_br_o, copy_src_o, copy_dst_o;
  logic [3:0] bist_fail_i, act_rank_o;
  int fail_count = 0;
  int n_compared = 0;

  always #2 clk_i = ~clk_i;

  mras_top u_dut (.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .rd_req_i,
    .wr_req_i, .req_br_i, .rd_br_o, .wr_br_o, .fatal_err_i, .rec_err_i,
    .alert_i, .ce_err_i, .ce_rank_i, .nmi_o, .frst_o, .frst_done_i,
    .retry_o, .retry_done_i, .retry_ok_i, .bist_run_o, .bist_done_i,
    .bist_fail_i, .copy_o, .copy_src_o, .copy_dst_o, .copy_done_i,
    .act_rank_o, .sb_lane_ok_i, .nb_lane_ok_i, .sb_fo_o, .nb_fo_o);

  mras_dimm_model #(.DLY(8)) u_mod (.clk_i, .rst_i, .frst_i(frst_o),
    .retry_i(retry_o), .bist_i(bist_run_o), .copy_i(copy_o), .ok_i(ok_set),
    .fail_i(fail_set), .frst_done_o(frst_done_i),
    .retry_done_o(retry_done_i), .retry_ok_o(retry_ok_i),
    .bist_done_o(bist_done_i), .bist_fail_o(bist_fail_i),
    .copy_done_o(copy_done_i));

  // verdict and end of run
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : wrap_up

  // one comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // classic single wishbone cycle, held until ack
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      fail_count++;
      wrap_up();
    end
    r = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
    @(posedge clk_i);
  endtask : wb

  // level watched by wt: 0 self-test, 1 copy, 2 retry, 3 fast reset
  function automatic logic lvl(input int s);
    return (s == 0) ? bist_run_o : (s == 1) ? copy_o :
           (s == 2) ? retry_o : frst_o;
  endfunction : lvl

  // bounded wait on one request level
  task automatic wt(input int s, input logic v);
    int n;
    logic x;
    n = 0;
    x = lvl(s);
    while (x !== v) begin
      @(posedge clk_i);
      n++;
      x = lvl(s);
      if (n > 300) begin
        fail_count++;
        wrap_up();
      end
    end
  endtask : wt

  // pulse one error input for a single cycle
  task automatic pulse(input int s);
    if (s == 0) rec_err_i <= 1'b1;
    else if (s == 1) fatal_err_i <= 1'b1;
    else alert_i <= 1'b1;
    @(posedge clk_i);
    {rec_err_i, fatal_err_i, alert_i} <= 3'b000;
  endtask : pulse

  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    // the spare has to be chosen before the self-test ends
    wb(1, OFS_CTRL, 32'h0f, rd);   // mirror, spare rank 3
    wt(0, 1'b1);
    chk({sb_fo_o, nb_fo_o}, 2'b01);
    wb(0, OFS_THRESH, 0, rd); chk(rd, 32'h0a);
    wb(0, 8'h40, 0, rd); chk(rd, 0);
    wb(1, OFS_CNT, 32'hff, rd);
    wt(0, 1'b0);
    chk(act_rank_o, 4'h5);
    // mirrored steering
    rd_req_i <= 1;
    wr_req_i <= 1;
    @(posedge clk_i); chk({rd_br_o, wr_br_o}, 4'h7);
    @(posedge clk_i); chk(rd_br_o, 2'b10);
    wb(1, OFS_CTRL, 32'h2f, rd);   // branch 1 off
    @(posedge clk_i); chk(wr_br_o, 2'b01);
    wb(1, OFS_CTRL, 32'h0e, rd);   // mirroring dropped
    req_br_i <= 1;
    @(posedge clk_i); chk({rd_br_o, wr_br_o}, 4'ha);
    {rd_req_i, wr_req_i} <= 2'b00;
    // ten errors stay under threshold, the eleventh spares
    ce_err_i <= 1;
    repeat (10) @(posedge clk_i);
    ce_err_i <= 0;
    repeat (3) @(posedge clk_i); chk(copy_o, 0);
    wb(0, OFS_CNT, 0, rd); chk(rd, 32'h0a);
    pulse(2);
    ce_err_i <= 1;
    @(posedge clk_i);
    ce_err_i <= 0;
    @(posedge clk_i); chk(frst_o, 1);
    wt(1, 1'b1);
    chk({copy_src_o, copy_dst_o}, 4'h3);
    wt(1, 1'b0);
    wb(0, OFS_STAT, 0, rd); chk(rd, 32'h2c4a);
    wb(0, OFS_CNT, 0, rd); chk(rd, 0);
    // saturate rank 2, then leak to zero
    ce_rank_i <= 2;
    ce_err_i <= 1;
    repeat (300) @(posedge clk_i);
    ce_err_i <= 0;
    wb(0, OFS_CNT, 0, rd); chk(rd, 32'h00ff0000);
    wb(1, OFS_DECAY, 32'h1, rd);
    repeat (600) @(posedge clk_i);
    wb(0, OFS_CNT, 0, rd); chk(rd, 0);
    wb(1, OFS_DECAY, 0, rd);
    // recoverable error, one bad south lane, retry passes, then fails; fatal error
    sb_lane_ok_i <= 10'h3f7;
    pulse(0);
    wt(2, 1'b1); chk({sb_fo_o, nb_fo_o}, 2'b11);
    wt(2, 1'b0);
    repeat (2) @(posedge clk_i); chk(nmi_o, 0);
    ok_set <= 0;
    pulse(0);
    wt(2, 1'b1);
    wt(2, 1'b0);
    repeat (2) @(posedge clk_i); chk(nmi_o, 1);
    wb(1, OFS_STAT, 32'h1, rd);
    @(posedge clk_i); chk(nmi_o, 0);
    pulse(1);
    repeat (2) @(posedge clk_i); chk(nmi_o, 1);
    // runtime loss of two south lanes: link fail, handled as fatal
    wb(1, OFS_STAT, 32'h1, rd); chk(nmi_o, 0);
    sb_lane_ok_i <= 10'h3f3;
    pulse(2);
    wt(3, 1'b1);
    wt(3, 1'b0);
    @(posedge clk_i); chk(nmi_o, 1);
    wb(0, OFS_STAT, 0, rd); chk(rd[ST_LINK], 1);
    wrap_up();
  end
endmodule : testbench
